// file: inc/lba_consts.svh
// Constants for the local bus arbiter control block
`ifndef LBA_CONSTS_SVH
`define LBA_CONSTS_SVH
`define LBA_IRQ_LVL_W      3
`define LBA_ADDR_W         32
`define LBA_LVL_LSB        1
`define LBA_TIMEOUT_NS     16000
`define LBA_CLK_PERIOD_NS  8
`define LBA_TIMEOUT_CYC    (`LBA_TIMEOUT_NS / `LBA_CLK_PERIOD_NS)
`define LBA_CNT_W          12
`define LBA_STRAP_DLY      4'h3
`endif

// file: inc/lba_pkg.sv
// Types for the local bus arbiter control block
package lba_pkg;
	typedef enum logic [3:0] {
		LBA_IDLE     = 4'b0001,
		LBA_REQ      = 4'b0010,
		LBA_OWN_SELF = 4'b0100,
		LBA_OWN_EXT  = 4'b1000
	} lba_state_t;

	typedef struct packed {
		logic       iack;
		logic       autovec;
		logic [2:0] level;
	} lba_iack_t;
endpackage : lba_pkg

// file: hdl/lba_watchdog.sv
// Local bus transfer watchdog raising bus error
`timescale 1ns/1ns
`include "lba_consts.svh"
module lba_watchdog #(
	parameter int TIMEOUT_CYC = `LBA_TIMEOUT_CYC
) (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic strobe_n_in,
	input  wire logic invalid_in,
	output logic      berr_n_out
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        berr_q;
	logic        berr_d;

	always_comb begin
		cnt_d  = cnt_q;
		berr_d = berr_q;
		if (strobe_n_in) begin
			// Error ends with the cycle's strobe
			cnt_d  = 32'h0;
			berr_d = 1'b0;
		end else begin
			if (cnt_q != TIMEOUT_CYC[31:0]) begin
				cnt_d = cnt_q + 32'h1;
			end
			if (invalid_in || (cnt_q == TIMEOUT_CYC[31:0] - 32'h1)) begin
				berr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q  <= 32'h0;
			berr_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			berr_q <= berr_d;
		end
	end

	assign berr_n_out = ~berr_q;
endmodule : lba_watchdog

// file: hdl/lba_ctrl.sv
// Local bus arbitration, interrupt acknowledge and bus error control
`timescale 1ns/1ns
`include "lba_consts.svh"
// Contract
// - During interrupt acknowledge, drive acknowledged level onto address bits 3..1.
// - Address strobe, low, qualifies the address; the master drives it.
// - Assert autovector low during an autovectored interrupt acknowledge cycle.
// - Assert bus error low on local transfer time-out or invalid transfer.
// - Drive grant acknowledge low while this device holds local bus mastership.
// - Active arbiter: every bus owner asserts grant acknowledge.
// - Bypass mode: grant acknowledge value is undefined and not relied on.
// - After reset, sample grant acknowledge: high active arbiter, low bypass.
// - Pull-down on grant acknowledge at power-up bypasses the arbiter.
// - Active arbiter, CPU grant for own request: acknowledge the grant itself.
// - Active arbiter, CPU grant for local requester: assert requester grant.
// - Assert CPU bus request while the local requester requests the bus; the active arbiter here withdraws it once granted.
module lba_ctrl #(
	parameter int TIMEOUT_CYC = `LBA_TIMEOUT_CYC
) (
	input  wire logic                    clk_in,
	input  wire logic                    arst_n_in,
	input  wire logic                    requester_request_n_in,
	input  wire logic                    self_request_in,
	input  wire logic                    cpu_grant_n_in,
	input  wire logic                    grant_ack_n_in,
	input  wire logic                    local_addr_strobe_n_in,
	input  wire logic                    invalid_xfer_in,
	input  wire lba_pkg::lba_iack_t      iack_in,
	output logic                         cpu_request_n_out,
	output logic                         requester_grant_n_out,
	output logic                         grant_ack_n_out,
	output logic                         grant_ack_oe_out,
	output logic                         self_owns_out,
	output logic                         local_addr_strobe_n_out,
	output logic                         local_addr_strobe_oe_out,
	output logic [`LBA_ADDR_W-1:0]       local_addr_lines_out,
	output logic                         local_addr_lines_oe_out,
	output logic                         autovector_n_out,
	output logic                         local_bus_error_n_out,
	output logic                         local_bus_error_oe_out,
	output logic                         bypass_out
);
	lba_pkg::lba_state_t st_q;
	lba_pkg::lba_state_t st_d;
	logic [3:0]          strap_cnt_q;
	logic [3:0]          strap_cnt_d;
	logic                bypass_q;
	logic                bypass_d;
	logic                strap_done;
	logic                req_q;
	logic                req_d;
	logic                rgnt_q;
	logic                rgnt_d;
	logic                gack_q;
	logic                gack_d;
	logic                own_self;
	logic [`LBA_ADDR_W-1:0] addr_q;
	logic [`LBA_ADDR_W-1:0] addr_d;
	logic                iack_q;
	logic                iack_d;
	logic                avec_q;
	logic                avec_d;
	logic                as_q;
	logic                as_d;
	logic                berr_n;

	assign strap_done = (strap_cnt_q == `LBA_STRAP_DLY);

	// Strap is caught by the third clock after release, never by the reset itself
	always_comb begin
		strap_cnt_d = strap_cnt_q;
		bypass_d    = bypass_q;
		if (!strap_done) begin
			strap_cnt_d = strap_cnt_q + 4'h1;
			if (strap_cnt_q == `LBA_STRAP_DLY - 4'h1) begin
				bypass_d = ~grant_ack_n_in;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_cnt_q <= 4'h0;
			bypass_q    <= 1'b0;
		end else begin
			strap_cnt_q <= strap_cnt_d;
			bypass_q    <= bypass_d;
		end
	end

	// Arbitration; self request wins over the local requester on a tie
	always_comb begin
		st_d   = st_q;
		req_d  = 1'b0;
		rgnt_d = 1'b0;
		gack_d = 1'b0;
		case (st_q)
			lba_pkg::LBA_IDLE: begin
				if (strap_done && !bypass_q && (self_request_in || !requester_request_n_in)) begin
					st_d  = lba_pkg::LBA_REQ;
					req_d = 1'b1;
				end
			end
			lba_pkg::LBA_REQ: begin
				req_d = 1'b1;
				if (!self_request_in && requester_request_n_in) begin
					st_d  = lba_pkg::LBA_IDLE;
					req_d = 1'b0;
				end else if (!cpu_grant_n_in && grant_ack_n_in) begin
					req_d = 1'b0;
					if (self_request_in) begin
						st_d   = lba_pkg::LBA_OWN_SELF;
						gack_d = 1'b1;
					end else begin
						st_d   = lba_pkg::LBA_OWN_EXT;
						rgnt_d = 1'b1;
					end
				end
			end
			lba_pkg::LBA_OWN_SELF: begin
				gack_d = self_request_in;
				if (!self_request_in) begin
					st_d = lba_pkg::LBA_IDLE;
				end
			end
			lba_pkg::LBA_OWN_EXT: begin
				rgnt_d = !requester_request_n_in;
				if (requester_request_n_in) begin
					st_d = lba_pkg::LBA_IDLE;
				end
			end
			default: begin
				st_d = lba_pkg::LBA_IDLE;
			end
		endcase
		if (bypass_q) begin
			req_d = !requester_request_n_in;
			st_d  = lba_pkg::LBA_IDLE;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q   <= lba_pkg::LBA_IDLE;
			req_q  <= 1'b0;
			rgnt_q <= 1'b0;
			gack_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			req_q  <= req_d;
			rgnt_q <= rgnt_d;
			gack_q <= gack_d;
		end
	end

	assign own_self = gack_q;

	// Interrupt acknowledge drive whenever iack_in.iack is set, whichever device owns the bus
	always_comb begin
		addr_d = '0;
		iack_d = iack_in.iack;
		avec_d = iack_in.iack && iack_in.autovec;
		// Follows next ownership so strobe and grant ack move on one edge
		as_d   = gack_d;
		if (iack_in.iack) begin
			addr_d[`LBA_LVL_LSB +: `LBA_IRQ_LVL_W] = iack_in.level;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			addr_q <= '0;
			iack_q <= 1'b0;
			avec_q <= 1'b0;
			as_q   <= 1'b0;
		end else begin
			addr_q <= addr_d;
			iack_q <= iack_d;
			avec_q <= avec_d;
			as_q   <= as_d;
		end
	end

	lba_watchdog #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_wd (
		.clk_in      (clk_in),
		.arst_n_in   (arst_n_in),
		.strobe_n_in (local_addr_strobe_n_in),
		.invalid_in  (invalid_xfer_in),
		.berr_n_out  (berr_n)
	);

	assign cpu_request_n_out        = ~req_q;
	assign requester_grant_n_out    = ~rgnt_q;
	// Open drain: drive low only; bypass leaves it released
	assign grant_ack_n_out          = 1'b0;
	assign grant_ack_oe_out         = gack_q && !bypass_q;
	assign self_owns_out            = own_self;
	assign local_addr_strobe_n_out  = ~as_q;
	assign local_addr_strobe_oe_out = as_q;
	assign local_addr_lines_out     = addr_q;
	assign local_addr_lines_oe_out  = iack_q;
	assign autovector_n_out         = ~avec_q;
	assign local_bus_error_n_out    = 1'b0;
	assign local_bus_error_oe_out   = ~berr_n;
	assign bypass_out               = bypass_q;
endmodule : lba_ctrl

// file: bench/lba_ctrl_monitor.sv
// Port checker for the local bus arbiter control block
`timescale 1ns/1ns
module lba_ctrl_monitor (
	input wire logic               clk_in,
	input wire logic               arst_n_in,
	input wire logic               requester_request_n_in,
	input wire logic               self_request_in,
	input wire logic               cpu_grant_n_in,
	input wire logic               grant_ack_n_in,
	input wire logic               local_addr_strobe_n_in,
	input wire logic               invalid_xfer_in,
	input wire logic               cpu_request_n_out,
	input wire logic               requester_grant_n_out,
	input wire logic               grant_ack_oe_out,
	input wire logic               self_owns_out,
	input wire logic               local_addr_strobe_n_out,
	input wire logic               local_addr_strobe_oe_out,
	input wire logic               local_addr_lines_oe_out,
	input wire logic               autovector_n_out,
	input wire logic               local_bus_error_oe_out,
	input wire logic               bypass_out,
	input wire lba_pkg::lba_iack_t iack_in,
	input wire logic [31:0]        local_addr_lines_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	a_iack_level: assert property (iack_in.iack |=> local_addr_lines_oe_out &&
		local_addr_lines_out[3:1] == $past(iack_in.level)) else $error("iack level wrong");
	a_autovec_low: assert property (iack_in.iack && iack_in.autovec |=>
		!autovector_n_out) else $error("autovector missing");
	a_berr_invalid: assert property (!local_addr_strobe_n_in && invalid_xfer_in |=>
		local_bus_error_oe_out) else $error("bus error missing");
	a_berr_clear: assert property (local_addr_strobe_n_in |=>
		!local_bus_error_oe_out) else $error("bus error stuck");
	a_own_ack: assert property (self_owns_out |-> grant_ack_oe_out && !grant_ack_n_in)
		else $error("owner not acknowledging");
	a_own_strobe: assert property (self_owns_out |-> local_addr_strobe_oe_out &&
		!local_addr_strobe_n_out) else $error("owner strobe missing");
	a_self_grant: assert property (!bypass_out && self_request_in && !cpu_request_n_out &&
		!cpu_grant_n_in && grant_ack_n_in |=> grant_ack_oe_out) else $error("no self ack");
	a_req_grant: assert property (!bypass_out && !self_request_in &&
		!requester_request_n_in && !cpu_request_n_out && !cpu_grant_n_in && grant_ack_n_in
		|=> !requester_grant_n_out) else $error("no requester grant");
	a_bypass_quiet: assert property (bypass_out |-> !grant_ack_oe_out &&
		requester_grant_n_out) else $error("bypass grants");
	a_req_withdraw: assert property (grant_ack_oe_out || !requester_grant_n_out |->
		cpu_request_n_out) else $error("request not withdrawn");
	a_bypass_req: assert property (bypass_out |=>
		cpu_request_n_out == $past(requester_request_n_in)) else $error("request not passed");
	c_self: cover property (grant_ack_oe_out);
	c_ext: cover property (!requester_grant_n_out);
	c_berr: cover property (local_bus_error_oe_out);
endmodule : lba_ctrl_monitor
bind lba_ctrl lba_ctrl_monitor u_mon (.*);

// file: bench/lba_cpu_model.sv
// Partner model: local CPU arbiter and local requester acknowledge
`timescale 1ns/1ns
module lba_cpu_model (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       req_n_in,
	input  wire logic       ack_n_in,
	input  wire logic       rgnt_n_in,
	input  wire logic [1:0] dly_in,
	output logic            grant_n_out,
	output logic            ext_ack_out
);
	logic [1:0] cnt_q;
	// Slow CPU waits dly_in cycles before granting
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 2'h0;
			grant_n_out <= 1'b1;
			ext_ack_out <= 1'b0;
		end else begin
			cnt_q <= (req_n_in || !ack_n_in) ? 2'h0 : cnt_q + (cnt_q != dly_in);
			grant_n_out <= !(!req_n_in && ack_n_in && cnt_q == dly_in);
			ext_ack_out <= !rgnt_n_in;
		end
	end
endmodule : lba_cpu_model

// file: bench/lba_ctrl_tb_top.sv
// Testbench for the local bus arbiter control block
`timescale 1ns/1ns
module lba_ctrl_tb_top;
	logic clk_in = 0, arst_n_in = 0, rq_n = 1, self_req = 0, strobe_n = 1, inv = 0, pd = 0;
	logic [1:0] dly = 2'h0;
	lba_pkg::lba_iack_t iack = '0;
	logic cpu_req_n, rq_gnt_n, ack_oe, owns, as_n, as_oe, a_oe, av_n, be_oe, byp, gnt_n, ext;
	logic [31:0] addr;
	int err_count = 0, checked = 0;
	// Open-drain wires: pull-up unless someone pulls low
	wire ack_n = !(ack_oe | ext | pd);
	wire as_w = strobe_n & !(as_oe & !as_n);
	always #4 clk_in = ~clk_in;
	lba_ctrl #(.TIMEOUT_CYC(8)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.requester_request_n_in(rq_n), .self_request_in(self_req), .cpu_grant_n_in(gnt_n),
		.grant_ack_n_in(ack_n), .local_addr_strobe_n_in(as_w), .invalid_xfer_in(inv),
		.iack_in(iack), .cpu_request_n_out(cpu_req_n), .requester_grant_n_out(rq_gnt_n),
		.grant_ack_n_out(), .grant_ack_oe_out(ack_oe), .self_owns_out(owns),
		.local_addr_strobe_n_out(as_n), .local_addr_strobe_oe_out(as_oe),
		.local_addr_lines_out(addr), .local_addr_lines_oe_out(a_oe),
		.autovector_n_out(av_n), .local_bus_error_n_out(), .local_bus_error_oe_out(be_oe),
		.bypass_out(byp));
	lba_cpu_model cpu (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_n_in(cpu_req_n),
		.ack_n_in(ack_n), .rgnt_n_in(rq_gnt_n), .dly_in(dly), .grant_n_out(gnt_n),
		.ext_ack_out(ext));
	task test_done();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task tk();
		@(posedge clk_in);
		#1;
	endtask : tk
	// Bounded wait; a hang ends the run
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 20 && s !== v; i++) tk();
		if (s !== v) begin
			err_count++;
			$display("CHECK FAILED wait expected %h seen %h", v, s);
			test_done();
		end
	endtask : wt
	task rst(input logic p);
		@(posedge clk_in) begin arst_n_in <= 0; pd <= p; end
		repeat (5) tk();
		chk("reset outs", {cpu_req_n, rq_gnt_n, av_n, ack_oe, be_oe, byp}, 6'h38);
		@(posedge clk_in) arst_n_in <= 1;
		repeat (5) tk();
		chk("mode", byp, p);
	endtask : rst
	task t_ext();
		@(posedge clk_in) rq_n <= 0;
		wt(cpu_req_n, 0);
		wt(rq_gnt_n, 0);
		chk("req off", cpu_req_n, 1);
		tk();
		chk("ext ack", {ack_n, ack_oe, owns}, 3'h0);
		@(posedge clk_in) rq_n <= 1;
		wt(rq_gnt_n, 1);
		$display("requester grant done");
	endtask : t_ext
	task t_self();
		@(posedge clk_in) begin self_req <= 1; dly <= 2'h3; end
		wt(ack_oe, 1);
		chk("own", {owns, as_oe, as_n, ack_n, cpu_req_n}, 5'h19);
		@(posedge clk_in) self_req <= 0;
		wt(ack_oe, 0);
		$display("self grant done");
	endtask : t_self
	task t_iack();
		for (int lv = 0; lv < 8; lv++) begin
			@(posedge clk_in) iack <= '{1'b1, lv[0], lv[2:0]};
			tk();
			chk("level", addr, {28'h0, lv[2:0], 1'b0});
			chk("level oe", a_oe, 1'b1);
			chk("autovec", av_n, !lv[0]);
		end
		@(posedge clk_in) iack <= '0;
		tk();
		chk("iack end", {a_oe, av_n}, 2'h1);
		$display("iack done");
	endtask : t_iack
	task t_berr();
		@(posedge clk_in) begin strobe_n <= 0; inv <= 1; end
		tk();
		chk("invalid", be_oe, 1);
		@(posedge clk_in) begin strobe_n <= 1; inv <= 0; end
		tk();
		@(posedge clk_in) strobe_n <= 0;
		// Eight strobe-low edges with the time-out of 8 used here
		repeat (7) tk();
		chk("early", be_oe, 0);
		tk();
		chk("timeout", be_oe, 1);
		wt(be_oe, 1);
		@(posedge clk_in) strobe_n <= 1;
		wt(be_oe, 0);
		$display("bus error done");
	endtask : t_berr
	task t_byp();
		rst(1);
		@(posedge clk_in) rq_n <= 0;
		repeat (3) tk();
		chk("byp", {cpu_req_n, rq_gnt_n, ack_oe}, 3'h2);
		@(posedge clk_in) rq_n <= 1;
		repeat (2) tk();
		chk("byp off", cpu_req_n, 1);
		$display("bypass done");
	endtask : t_byp
	initial begin
		rst(0);
		t_ext();
		t_self();
		t_iack();
		t_berr();
		t_byp();
		test_done();
	end
endmodule : lba_ctrl_tb_top
